// File: common/ccrc_pkg.sv
package ccrc_pkg;

   // Register bus geometry.
   localparam int unsigned CCRC_ADDR_W = 4;
   localparam int unsigned CCRC_DATA_W = 16;
   localparam int unsigned CCRC_NUM_CMP = 3;

   // Register offsets (word index on the register port).
   localparam logic [3:0] CCRC_OFS_CMP1_CTRL = 4'h0;
   localparam logic [3:0] CCRC_OFS_CMP2_CTRL = 4'h1;
   localparam logic [3:0] CCRC_OFS_CMP3_CTRL = 4'h2;
   localparam logic [3:0] CCRC_OFS_STATUS = 4'h3;
   localparam logic [3:0] CCRC_OFS_REF_CTRL = 4'h4;
   localparam logic [3:0] CCRC_OFS_IRQ_STATUS = 4'h5;
   localparam logic [3:0] CCRC_OFS_IRQ_ENABLE = 4'h6;
   localparam logic [3:0] CCRC_OFS_IRQ_CLEAR = 4'h7;

   // Comparator control field positions.
   localparam int unsigned CCRC_CC_ENABLE = 15;
   localparam int unsigned CCRC_CC_PIN_OE = 14;
   localparam int unsigned CCRC_CC_INVERT = 13;
   localparam int unsigned CCRC_CC_EVENT = 9;
   localparam int unsigned CCRC_CC_RESULT = 8;
   localparam int unsigned CCRC_CC_EVPOL_LO = 6;
   localparam int unsigned CCRC_CC_NONINV = 4;
   localparam int unsigned CCRC_CC_CHAN_LO = 0;

   // Status register field positions.
   localparam int unsigned CCRC_ST_IDLE_SUPP = 15;
   localparam int unsigned CCRC_ST_EVENT_LO = 8;
   localparam int unsigned CCRC_ST_RESULT_LO = 0;

   // Writable masks; every other position reads as zero, except the read-only result bit of the control registers.
   localparam logic [15:0] CCRC_CC_WMASK = 16'he2d3;
   localparam logic [15:0] CCRC_REF_WMASK = 16'h00ff;

   // Reset values.
   localparam logic [15:0] CCRC_CC_RESET = 16'h0000;
   localparam logic [15:0] CCRC_REF_RESET = 16'h0000;

   // Inverting input selections.
   typedef enum logic [1:0] {
      CCRC_INV_PIN_B = 2'h0,
      CCRC_INV_PIN_C = 2'h1,
      CCRC_INV_PIN_D = 2'h2,
      CCRC_INV_HALF_BANDGAP = 2'h3
   } ccrc_inv_sel_t;

   // Event polarity modes.
   typedef enum logic [1:0] {
      CCRC_EV_OFF = 2'h0,
      CCRC_EV_RISE = 2'h1,
      CCRC_EV_FALL = 2'h2,
      CCRC_EV_ANY = 2'h3
   } ccrc_evpol_t;

   // Analog steering of one comparator.
   typedef struct packed {
      logic enable;
      logic pin_oe;
      logic noninv_input_select;
      ccrc_inv_sel_t inverting_channel_select;
   } ccrc_cmp_ana_t;

   // Reference ladder controls.
   typedef struct packed {
      logic ref_generator_enable;
      logic ref_pin_output_enable;
      logic ref_range_select;
      logic ref_supply_select;
      logic [3:0] ref_level_code;
   } ccrc_ref_ana_t;

endpackage

// File: rtl/ccrc_cmp_chan.sv
`timescale 1ns/1ps
// One comparator channel: result synchroniser, polarity, event detection.
module ccrc_cmp_chan
   import ccrc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Analog side.
   input wire logic raw_out,
   // Configuration.
   input wire logic output_invert,
   input wire ccrc_evpol_t evpol,
   input wire logic event_flag,
   // Results.
   output logic comparator_result,
   output logic event_hit
);

   // Two-stage synchroniser for the asynchronous analog output.
   logic sync1_q;
   logic sync2_q;
   // Previous polarised result, for edge detection.
   logic prev_q;
   // Polarised result.
   logic pol_res;

   // Synchroniser chain; first stage feeds only the second.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= raw_out;
         sync2_q <= sync1_q;
      end
   end

   assign pol_res = sync2_q ^ output_invert;

   // Remember the last reported result.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pol_res;
      end
   end

   assign comparator_result = pol_res;

   // Event detection is blocked while the flag is set.
   always_comb begin
      event_hit = 1'b0;
      if (!event_flag) begin
         unique case (evpol)
            CCRC_EV_OFF: event_hit = 1'b0;
            CCRC_EV_RISE: event_hit = pol_res & ~prev_q;
            CCRC_EV_FALL: event_hit = ~pol_res & prev_q;
            CCRC_EV_ANY: event_hit = pol_res ^ prev_q;
         endcase
      end
   end

endmodule // ccrc_cmp_chan

// File: rtl/ccrc_top.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module ccrc_top
   import ccrc_pkg::*;
#(
   parameter int unsigned NUM_CMP = CCRC_NUM_CMP
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_b,
   // Register port.
   input wire logic [CCRC_ADDR_W-1:0] reg_addr,
   input wire logic [CCRC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [CCRC_DATA_W-1:0] reg_rdata,
   // Device power state.
   input wire logic device_idle,
   // Analog comparator side.
   input wire logic [NUM_CMP-1:0] cmp_raw_out,
   output ccrc_cmp_ana_t [NUM_CMP-1:0] cmp_ana,
   output logic [NUM_CMP-1:0] cmp_trigger,
   // Reference ladder side.
   output ccrc_ref_ana_t ref_ana,
   // Interrupt.
   output logic irq
);

   // Writable part of each comparator control register.
   logic [CCRC_DATA_W-1:0] cc_q [NUM_CMP];
   // Event flags, set by hardware and cleared by software.
   logic [NUM_CMP-1:0] evt_q;
   // Idle interrupt suppression control.
   logic idle_interrupt_suppress_q;
   // Reference control register.
   logic [CCRC_DATA_W-1:0] ref_q;
   // Sticky interrupt status and its enable.
   logic [NUM_CMP-1:0] irq_st_q;
   logic [NUM_CMP-1:0] irq_en_q;
   // Read data register.
   logic [CCRC_DATA_W-1:0] rdata_q;
   // Idle synchroniser.
   logic idle_s1_q;
   logic idle_s2_q;
   // Per-channel results.
   logic [NUM_CMP-1:0] res;
   logic [NUM_CMP-1:0] hit;
   // Software clear of event flags this cycle.
   logic [NUM_CMP-1:0] evt_clr;
   logic [NUM_CMP-1:0] evt_wval;

   // Returns the comparator index addressed, or NUM_CMP when none.
   function automatic int unsigned cc_index(input logic [CCRC_ADDR_W-1:0] a);
      int unsigned r;
      r = NUM_CMP;
      for (int unsigned i = 0; i < NUM_CMP; i++) begin
         if (a == CCRC_OFS_CMP1_CTRL + CCRC_ADDR_W'(i)) begin
            r = i;
         end
      end
      return r;
   endfunction

   // Synchronise the idle indication from the power controller.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         idle_s1_q <= 1'b0;
         idle_s2_q <= 1'b0;
      end else begin
         idle_s1_q <= device_idle;
         idle_s2_q <= idle_s1_q;
      end
   end

   // One channel per comparator.
   for (genvar g = 0; g < NUM_CMP; g++) begin : g_chan
      ccrc_cmp_chan u_chan (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .raw_out(cmp_raw_out[g]),
         .output_invert(cc_q[g][CCRC_CC_INVERT]),
         .evpol(ccrc_evpol_t'(cc_q[g][CCRC_CC_EVPOL_LO +: 2])),
         .event_flag(evt_q[g]),
         .comparator_result(res[g]),
         .event_hit(hit[g])
      );

      // Analog steering straight from the control register.
      assign cmp_ana[g].enable = cc_q[g][CCRC_CC_ENABLE];
      assign cmp_ana[g].pin_oe = cc_q[g][CCRC_CC_PIN_OE];
      assign cmp_ana[g].noninv_input_select = cc_q[g][CCRC_CC_NONINV];
      assign cmp_ana[g].inverting_channel_select =
         ccrc_inv_sel_t'(cc_q[g][CCRC_CC_CHAN_LO +: 2]);
      // Trigger pulses only while enabled and the flag is clear.
      assign cmp_trigger[g] = hit[g] & cc_q[g][CCRC_CC_ENABLE];

      // Software clear of the event flag by writing zero to it.
      assign evt_clr[g] = reg_wr && (cc_index(reg_addr) == g) && !reg_wdata[CCRC_CC_EVENT];
      assign evt_wval[g] = reg_wr && (cc_index(reg_addr) == g) && reg_wdata[CCRC_CC_EVENT];
   end

   // Control register writes; read-only result bit is masked off.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < NUM_CMP; i++) begin
            cc_q[i] <= CCRC_CC_RESET;
         end
      end else if (reg_wr && cc_index(reg_addr) < NUM_CMP) begin
         cc_q[cc_index(reg_addr)] <= reg_wdata & CCRC_CC_WMASK;
      end
   end

   // Event flags: a hardware event wins over a software clear.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         evt_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (cmp_trigger[i]) begin
               evt_q[i] <= 1'b1;
            end else if (evt_clr[i]) begin
               evt_q[i] <= 1'b0;
            end else if (evt_wval[i]) begin
               evt_q[i] <= 1'b1;
            end
         end
      end
   end

   // Status register: only the idle suppression bit is writable.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         idle_interrupt_suppress_q <= 1'b0;
      end else if (reg_wr && reg_addr == CCRC_OFS_STATUS) begin
         idle_interrupt_suppress_q <= reg_wdata[CCRC_ST_IDLE_SUPP];
      end
   end

   // Reference control register; upper byte is not stored.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_q <= CCRC_REF_RESET;
      end else if (reg_wr && reg_addr == CCRC_OFS_REF_CTRL) begin
         ref_q <= reg_wdata & CCRC_REF_WMASK;
      end
   end

   // Reference ladder controls drive the analog generator directly.
   assign ref_ana = ccrc_ref_ana_t'(ref_q[7:0]);

   // Interrupt enable register.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_en_q <= '0;
      end else if (reg_wr && reg_addr == CCRC_OFS_IRQ_ENABLE) begin
         irq_en_q <= reg_wdata[NUM_CMP-1:0];
      end
   end

   // Sticky interrupt status; suppressed while idle, set wins over clear.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_st_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CMP; i++) begin
            if (cmp_trigger[i] && !(idle_interrupt_suppress_q && idle_s2_q)) begin
               irq_st_q[i] <= 1'b1;
            end else if (reg_wr && reg_addr == CCRC_OFS_IRQ_CLEAR && reg_wdata[i]) begin
               irq_st_q[i] <= 1'b0;
            end
         end
      end
   end

   // Level interrupt while any enabled status bit is set.
   assign irq = |(irq_st_q & irq_en_q);

   // Read mux; unmapped addresses and unimplemented bits read zero.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= '0;
      end else if (reg_rd) begin
         rdata_q <= '0;
         if (cc_index(reg_addr) < NUM_CMP) begin
            rdata_q <= cc_q[cc_index(reg_addr)];
            rdata_q[CCRC_CC_EVENT] <= evt_q[cc_index(reg_addr)];
            rdata_q[CCRC_CC_RESULT] <= res[cc_index(reg_addr)];
         end else begin
            unique case (reg_addr)
               CCRC_OFS_STATUS: begin
                  rdata_q[CCRC_ST_IDLE_SUPP] <= idle_interrupt_suppress_q;
                  rdata_q[CCRC_ST_EVENT_LO +: NUM_CMP] <= evt_q;
                  rdata_q[CCRC_ST_RESULT_LO +: NUM_CMP] <= res;
               end
               CCRC_OFS_REF_CTRL: rdata_q <= ref_q;
               CCRC_OFS_IRQ_STATUS: rdata_q[NUM_CMP-1:0] <= irq_st_q;
               CCRC_OFS_IRQ_ENABLE: rdata_q[NUM_CMP-1:0] <= irq_en_q;
               default: rdata_q <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_q;

endmodule // ccrc_top

// File: verification/ccrc_ana_model.sv
`timescale 1ns/1ps
// Comparator stand-in: a powered comparator reports the level the bench asks for.
module ccrc_ana_model
   import ccrc_pkg::*;
(
   // Steering from the block.
   input wire ccrc_cmp_ana_t [2:0] cmp_ana,
   // Wanted comparison result per comparator.
   input wire logic [2:0] level,
   // Raw outputs toward the block.
   output logic [2:0] raw_out
);
   // A powered-down comparator rests low.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         raw_out[i] = cmp_ana[i].enable & level[i];
      end
   end
endmodule // ccrc_ana_model

// File: verification/ccrc_asserts.sv
`timescale 1ns/1ps
// Watches the register port, the analog steering and the interrupt.
module ccrc_asserts
   import ccrc_pkg::*;
#(
   parameter int unsigned NUM_CMP = CCRC_NUM_CMP
) (
   // Watched pins.
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [CCRC_ADDR_W-1:0] reg_addr,
   input wire logic [CCRC_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [CCRC_DATA_W-1:0] reg_rdata,
   input wire logic device_idle,
   input wire logic [NUM_CMP-1:0] cmp_raw_out,
   input wire ccrc_cmp_ana_t [NUM_CMP-1:0] cmp_ana,
   input wire logic [NUM_CMP-1:0] cmp_trigger,
   input wire ccrc_ref_ana_t ref_ana,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Shadow of the idle suppress bit.
   logic supp_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         supp_q <= 1'b0;
      end else if (reg_wr && reg_addr == CCRC_OFS_STATUS) begin
         supp_q <= reg_wdata[CCRC_ST_IDLE_SUPP];
      end
   end
   ref_write_a: assert property (
      reg_wr && reg_addr == CCRC_OFS_REF_CTRL |=> ref_ana == ccrc_ref_ana_t'($past(reg_wdata[7:0])))
      else $error("reference controls differ from the write");
   ref_hold_a: assert property (
      !(reg_wr && reg_addr == CCRC_OFS_REF_CTRL) |=> $stable(ref_ana))
      else $error("reference controls moved without a write");
   chan_sel_a: assert property (
      reg_wr && reg_addr == CCRC_OFS_CMP1_CTRL |=> cmp_ana[0] == ccrc_cmp_ana_t'({$past(reg_wdata[15:14]),
         $past(reg_wdata[4]), $past(reg_wdata[1:0])}))
      else $error("input steering differs from the write");
   ref_zero_a: assert property (
      reg_rd && reg_addr == CCRC_OFS_REF_CTRL |=> reg_rdata[15:8] == 8'h00)
      else $error("reference upper byte not zero");
   ctrl_zero_a: assert property (
      reg_rd && reg_addr < CCRC_OFS_STATUS |=> (reg_rdata & 16'h1c2c) == 16'h0000)
      else $error("control spare bits not zero");
   stat_zero_a: assert property (
      reg_rd && reg_addr == CCRC_OFS_STATUS |=> (reg_rdata & 16'h78f8) == 16'h0000)
      else $error("status spare bits not zero");
   trig_once_a: assert property (
      cmp_trigger != '0 |=> (cmp_trigger & $past(cmp_trigger)) == '0)
      else $error("trigger repeated while event flag set");
   idle_quiet_a: assert property (
      (supp_q && device_idle) [*4] ##0 !$past(reg_wr) |-> !$rose(irq))
      else $error("interrupt raised while idle suppressed");
endmodule // ccrc_asserts

bind ccrc_top ccrc_asserts #(.NUM_CMP(NUM_CMP)) i_asserts (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle),
   .cmp_raw_out(cmp_raw_out), .cmp_ana(cmp_ana), .cmp_trigger(cmp_trigger), .ref_ana(ref_ana), .irq(irq));

// File: verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the comparator and reference register block.
module testbench
   import ccrc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic device_idle = 1'b0;
   logic [2:0] level = 3'h0;
   logic [15:0] reg_rdata;
   logic [2:0] raw;
   logic [2:0] cmp_trigger;
   logic irq;
   ccrc_cmp_ana_t [2:0] cmp_ana;
   ccrc_ref_ana_t ref_ana;
   // Model of control words, suppress bit, interrupt enable and status.
   int ctrl[3];
   int supp = 0;
   int ien = 0;
   int isr = 0;
   int n_errors = 0;
   int check_count = 0;
   logic [31:0] seed = 32'hc7f4b8e0;
   logic [15:0] d;
   // Trigger pulses seen so far, per comparator.
   int trig_n[3];

   // Count trigger pulses; the pulse is settled before the edge that samples it.
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (cmp_trigger[i] === 1'b1) begin
            trig_n[i]++;
         end
      end
   end

   // A 5 ns clock.
   always #2.5 sys_clk = ~sys_clk;

   ccrc_top #(.NUM_CMP(3)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .device_idle(device_idle), .cmp_raw_out(raw),
      .cmp_ana(cmp_ana), .cmp_trigger(cmp_trigger), .ref_ana(ref_ana), .irq(irq));
   ccrc_ana_model i_ana (.cmp_ana(cmp_ana), .level(level), .raw_out(raw));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Reported result: powered level, then the polarity bit.
   function automatic int res(input int i);
      return (((ctrl[i] >> 15) & int'(level[i])) ^ (ctrl[i] >> 13)) & 1;
   endfunction
   function automatic int st();
      int r;
      r = supp << 15;
      for (int i = 0; i < 3; i++) begin
         r = r | (((ctrl[i] >> 9) & 1) << (8 + i)) | (res(i) << i);
      end
      return r;
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // Read strobe for one cycle; data compared in the cycle after.
   task automatic rdc(input logic [3:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic irq_chk();
      chk(16'(irq), 16'((isr & ien) != 0));
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      end_sim();
   end

   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 16; a++) begin
         rdc(4'(a), 16'h0000);
      end
      $display("reset test done");
      repeat (20) begin
         seed = lfsr(seed);
         level <= seed[18:16];
         for (int i = 0; i < 3; i++) begin
            d = seed[15:0] & 16'hff3f;
            wr(4'(i), d);
            ctrl[i] = d & 16'he2d3;
            chk({11'h0, cmp_ana[i]}, {11'h0, d[15:14], d[4], d[1:0]});
         end
         wr(CCRC_OFS_STATUS, seed[31:16]);
         supp = seed[31];
         wr(CCRC_OFS_REF_CTRL, seed[31:16]);
         chk({8'h0, ref_ana}, {8'h0, seed[23:16]});
         for (int i = 0; i < 3; i++) begin
            rdc(4'(i), 16'(ctrl[i] | (res(i) << 8)));
         end
         rdc(CCRC_OFS_STATUS, 16'(st()));
         rdc(CCRC_OFS_REF_CTRL, {8'h00, seed[23:16]});
      end
      $display("random test done");
      wr(CCRC_OFS_STATUS, 16'h0000);
      supp = 0;
      wr(CCRC_OFS_IRQ_ENABLE, 16'h0007);
      ien = 7;
      rdc(CCRC_OFS_IRQ_ENABLE, 16'(ien));
      for (int i = 0; i < 3; i++) begin
         level <= 3'h0;
         wr(4'(i), 16'h8040);
         ctrl[i] = 16'h8040;
         repeat (4) @(posedge sys_clk);
         level <= 3'(1 << i);
         repeat (6) @(posedge sys_clk);
         ctrl[i] = ctrl[i] | 16'h0200;
         isr = isr | (1 << i);
         irq_chk();
         chk(16'(trig_n[i]), 16'h0001);
         rdc(CCRC_OFS_IRQ_STATUS, 16'(isr));
         rdc(CCRC_OFS_STATUS, 16'(st()));
         wr(CCRC_OFS_IRQ_CLEAR, 16'h0007);
         isr = 0;
         level <= 3'h0;
         repeat (4) @(posedge sys_clk);
         level <= 3'(1 << i);
         repeat (6) @(posedge sys_clk);
         irq_chk();
         chk(16'(trig_n[i]), 16'h0001);
         rdc(CCRC_OFS_IRQ_STATUS, 16'(isr));
         rdc(4'(i), 16'(ctrl[i] | (res(i) << 8)));
         wr(4'(i), 16'h8040);
         ctrl[i] = 16'h8040;
      end
      $display("event test done");
      level <= 3'h0;
      wr(CCRC_OFS_STATUS, 16'h8000);
      supp = 1;
      @(posedge sys_clk);
      device_idle <= 1'b1;
      repeat (4) @(posedge sys_clk);
      level <= 3'h7;
      repeat (6) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         ctrl[i] = ctrl[i] | 16'h0200;
         chk(16'(trig_n[i]), 16'h0002);
      end
      irq_chk();
      rdc(CCRC_OFS_STATUS, 16'(st()));
      rdc(CCRC_OFS_IRQ_STATUS, 16'h0000);
      $display("idle test done");
      // Suppression off: events while idle raise the interrupt as usual.
      wr(CCRC_OFS_STATUS, 16'h0000);
      supp = 0;
      level <= 3'h0;
      for (int i = 0; i < 3; i++) begin
         wr(4'(i), 16'h8040);
         ctrl[i] = 16'h8040;
      end
      repeat (4) @(posedge sys_clk);
      level <= 3'h7;
      repeat (6) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
         ctrl[i] = ctrl[i] | 16'h0200;
         chk(16'(trig_n[i]), 16'h0003);
      end
      isr = 7;
      irq_chk();
      rdc(CCRC_OFS_IRQ_STATUS, 16'(isr));
      rdc(CCRC_OFS_STATUS, 16'(st()));
      $display("idle run test done");
      end_sim();
   end
endmodule // testbench
